// file: core/flm_pkg.sv
// Purpose: shared constants for the frequency-locked loop monitor
// Assumes: 32-bit apb, one aligned word per register
// Notes: offsets are byte addresses
package flm_pkg;
  localparam int ADDR_W = 8;
  localparam int COARSE_W = 6;
  localparam int FINE_W = 10;
  localparam int MUL_W = 16;
  localparam int CNT_W = 18;
  localparam int STAT_W = 5;

  // register offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_MUL = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_VAL = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_INTFLAG = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_INTMASK = 8'h14;

  // control bit positions
  localparam int CTRL_ENABLE = 0;
  localparam int CTRL_CLOSED = 1;
  localparam int CTRL_STABLE = 2;

  // value register layout
  localparam int VAL_FINE_LSB = 0;
  localparam int VAL_COARSE_LSB = 10;
  localparam int VAL_DIFF_LSB = 16;

  // status, flag and mask layout
  localparam int ST_READY = 0;
  localparam int ST_COARSE_LOCK = 1;
  localparam int ST_FINE_LOCK = 2;
  localparam int ST_OOB = 3;
  localparam int ST_REF_STOP = 4;

  // reset values
  localparam logic [2:0] CTRL_RST = 3'h0;
  localparam logic [MUL_W-1:0] MUL_RST = 16'h05b8;
  localparam logic [COARSE_W-1:0] COARSE_RST = 6'h1f;
  localparam logic [FINE_W-1:0] FINE_RST = 10'h200;
  localparam logic [STAT_W-1:0] MASK_RST = 5'h00;

  // tuning limits in tuning steps, tolerances in output-clock counts
  localparam logic [COARSE_W-1:0] COARSE_MAX = 6'h3f;
  localparam logic [FINE_W-1:0] FINE_MAX = 10'h3ff;
  localparam logic [18:0] COARSE_TOL = 19'h00020;
  localparam logic [18:0] FINE_TOL = 19'h00001;

  // reference stop limit: twice the largest multiplier, in output edges
  localparam logic [MUL_W-1:0] MAX_MUL = 16'hffff;
  localparam logic [CNT_W-1:0] REF_STOP_LIMIT = {1'b0, MAX_MUL, 1'b0};
  localparam logic [2:0] READY_EDGES = 3'h7;

  typedef enum logic [2:0] {
    LS_OPEN = 3'b001,
    LS_COARSE = 3'b010,
    LS_FINE = 3'b100
  } flm_state_t;
endpackage

// file: core/flm_top.sv
// Purpose: closed-loop tuning and monitoring of a frequency-locked oscillator
// Assumes: both clock inputs are sampled synchronously on pclk
// Notes: tuning values drive the oscillator; apb slave answers with one wait-free access
//
// How it works
// RULE1 - closed loop first steps coarse tuning quickly toward the target ratio
// RULE2 - coarse stage done sets the coarse lock flag in power_clock_status
// RULE3 - after coarse lock, fine tuning steps until the ratio is very close
// RULE4 - fine stage done sets the fine lock flag in power_clock_status
// RULE5 - lock flag setting raises interrupt when its enable bit is one
// RULE6 - ready flag marks the output clock usable; lock flags tell accuracy
// RULE7 - each reference period measures the ratio, stores difference from multiplier
// RULE8 - with hold clear, fine tuning tracks drift every measurement, locks kept
// RULE9 - fine tuning overflow or underflow in closed loop sets out-of-bounds flag
// RULE10 - system must supply a stable external reference clock for closed loop
// RULE11 - reference stopped flag sets when reference is slower than out/(2*max)
// RULE12 - stop detection takes about two to the seventeen output cycles
// RULE13 - stopped reference freezes tuning as open loop, resumes on restart
// RULE14 - with hold set, fine tuning stays fixed after fine lock
//
// The APB register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module flm_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [flm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic loop_reference_clock,
  input wire logic loop_osc_clock_out,
  output logic [flm_pkg::COARSE_W-1:0] coarse_tune_value,
  output logic [flm_pkg::FINE_W-1:0] fine_tune_value,
  output logic loop_osc_ready_flag,
  output logic irq
);
  import flm_pkg::*;

  flm_state_t state;
  logic [2:0] ctrl;
  logic [MUL_W-1:0] multiply_ratio;
  logic [15:0] ratio_difference;
  logic [STAT_W-1:0] int_flag;
  logic [STAT_W-1:0] int_mask;
  logic [STAT_W-1:0] stat_q;
  logic coarse_lock_flag;
  logic fine_lock_flag;
  logic tune_out_of_bounds_flag;
  logic ref_clock_stopped_flag;
  logic ref_q;
  logic osc_q;
  logic armed;
  logic [CNT_W-1:0] osc_cnt;
  logic [2:0] ready_cnt;

  // bus decode
  wire setup = psel & ~penable;
  wire done = psel & penable & pready;
  wire wr_done = done & pwrite;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_mul = paddr == OFF_MUL;
  wire hit_val = paddr == OFF_VAL;
  wire hit_stat = paddr == OFF_STATUS;
  wire hit_flag = paddr == OFF_INTFLAG;
  wire hit_mask = paddr == OFF_INTMASK;
  wire mapped = hit_ctrl | hit_mul | hit_val | hit_stat | hit_flag | hit_mask;

  // control fields
  wire loop_enable = ctrl[CTRL_ENABLE];
  wire closed_req = ctrl[CTRL_CLOSED] & loop_enable;
  wire stable_freq_hold = ctrl[CTRL_STABLE];
  wire tuning_live = closed_req & ~ref_clock_stopped_flag; // see RULE13

  // edge detection on the sampled clock inputs
  wire ref_rise = loop_reference_clock & ~ref_q;
  wire osc_rise = loop_osc_clock_out & ~osc_q;
  wire ref_stop = osc_cnt >= REF_STOP_LIMIT; // see RULE11 see RULE12
  wire meas_valid = ref_rise & armed & tuning_live; // see RULE7

  // ratio error: positive means output too fast
  wire signed [18:0] err = $signed({1'b0, osc_cnt}) - $signed({3'b000, multiply_ratio});
  wire [18:0] err_mag = err[18] ? 19'(-err) : 19'(err);
  wire too_slow = err[18];
  wire err_zero = err == 19'sh0;
  wire [15:0] diff_sat = (err > 19'sh07fff) ? 16'h7fff :
                         (err < -19'sh08000) ? 16'h8000 : err[15:0];

  // tuning limit checks
  wire coarse_at_lim = too_slow ? (coarse_tune_value == COARSE_MAX)
                                : (coarse_tune_value == '0);
  wire fine_at_lim = too_slow ? (fine_tune_value == FINE_MAX) : (fine_tune_value == '0);
  wire coarse_done = (err_mag <= COARSE_TOL) | coarse_at_lim;
  wire fine_close = err_mag <= FINE_TOL;
  wire fine_frozen = fine_lock_flag & stable_freq_hold; // see RULE14
  wire fine_step = ~err_zero & ~fine_frozen & ~fine_at_lim;
  wire [COARSE_W-1:0] coarse_next = too_slow ? coarse_tune_value + 6'h01
                                             : coarse_tune_value - 6'h01;
  wire [FINE_W-1:0] fine_next = too_slow ? fine_tune_value + 10'h001
                                         : fine_tune_value - 10'h001;

  // status vector, events and interrupt flags
  wire [STAT_W-1:0] stat_now = {ref_clock_stopped_flag, tune_out_of_bounds_flag,
                                fine_lock_flag, coarse_lock_flag, loop_osc_ready_flag};
  wire [STAT_W-1:0] events = stat_now & ~stat_q;
  wire [STAT_W-1:0] rd_clr = (done & ~pwrite & hit_flag) ? prdata[STAT_W-1:0] : '0;
  wire [STAT_W-1:0] next_int_flag = (int_flag & ~rd_clr) | events;
  wire next_irq = |(next_int_flag & int_mask); // see RULE5

  // read mux
  wire [31:0] rd_data = hit_ctrl ? {29'h0, ctrl} :
                        hit_mul ? {16'h0, multiply_ratio} :
                        hit_val ? {ratio_difference, coarse_tune_value, fine_tune_value} :
                        hit_stat ? {27'h0, stat_now} :
                        hit_flag ? {27'h0, int_flag} :
                        hit_mask ? {27'h0, int_mask} : 32'h0;

  // apb answer, one cycle after setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else if (clk_en) begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      if (setup) begin
        prdata <= pwrite ? 32'h0 : rd_data;
      end
    end
  end

  // software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
      multiply_ratio <= MUL_RST;
      int_mask <= MASK_RST;
    end else if (clk_en && wr_done) begin
      if (hit_ctrl) begin
        ctrl <= pwdata[2:0];
      end
      if (hit_mul) begin
        multiply_ratio <= pwdata[MUL_W-1:0];
      end
      if (hit_mask) begin
        int_mask <= pwdata[STAT_W-1:0]; // see RULE5
      end
    end
  end

  // sticky flags, set beats read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_flag <= '0;
      stat_q <= '0;
      irq <= 1'b0;
    end else if (clk_en) begin
      int_flag <= next_int_flag;
      stat_q <= stat_now;
      irq <= next_irq; // see RULE5
    end
  end

  // input sampling and ratio counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
      osc_q <= 1'b0;
      osc_cnt <= '0;
      armed <= 1'b0;
    end else if (clk_en) begin
      ref_q <= loop_reference_clock;
      osc_q <= loop_osc_clock_out;
      if (!closed_req) begin
        osc_cnt <= '0;
        armed <= 1'b0;
      end else if (ref_rise) begin
        osc_cnt <= '0; // see RULE7
        armed <= 1'b1;
      end else if (ref_stop) begin
        armed <= 1'b0; // first edge after restart only restarts counting
      end else if (osc_rise) begin
        osc_cnt <= osc_cnt + 18'h00001;
      end
    end
  end

  // reference stop flag, cleared by the next reference edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_clock_stopped_flag <= 1'b0;
    end else if (clk_en) begin
      if (!closed_req || ref_rise) begin
        ref_clock_stopped_flag <= 1'b0; // see RULE13
      end else if (ref_stop) begin
        ref_clock_stopped_flag <= 1'b1; // see RULE11
      end
    end
  end

  // ready once the oscillator is enabled and toggling
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready_cnt <= '0;
      loop_osc_ready_flag <= 1'b0;
    end else if (clk_en) begin
      if (!loop_enable) begin
        ready_cnt <= '0;
        loop_osc_ready_flag <= 1'b0;
      end else if (osc_rise && ready_cnt != READY_EDGES) begin
        ready_cnt <= ready_cnt + 3'h1;
      end else if (ready_cnt == READY_EDGES) begin
        loop_osc_ready_flag <= 1'b1; // see RULE6
      end
    end
  end

  // measured difference from the programmed multiplier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ratio_difference <= 16'h0;
    end else if (clk_en && meas_valid) begin
      ratio_difference <= diff_sat; // see RULE7
    end
  end

  // lock sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= LS_OPEN;
    end else if (clk_en) begin
      unique case (state)
        LS_OPEN: begin
          if (closed_req) begin
            state <= LS_COARSE;
          end
        end
        LS_COARSE: begin
          if (!closed_req) begin
            state <= LS_OPEN;
          end else if (meas_valid && coarse_done) begin
            state <= LS_FINE; // see RULE3
          end
        end
        LS_FINE: begin
          if (!closed_req) begin
            state <= LS_OPEN;
          end
        end
        default: begin
          state <= LS_OPEN;
        end
      endcase
    end
  end

  // lock and bound flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coarse_lock_flag <= 1'b0;
      fine_lock_flag <= 1'b0;
      tune_out_of_bounds_flag <= 1'b0;
    end else if (clk_en) begin
      if (!closed_req) begin
        coarse_lock_flag <= 1'b0;
        fine_lock_flag <= 1'b0;
        tune_out_of_bounds_flag <= 1'b0;
      end else if (meas_valid) begin
        if (state == LS_COARSE && coarse_done) begin
          coarse_lock_flag <= 1'b1; // see RULE2
        end
        if (state == LS_FINE && fine_close) begin
          fine_lock_flag <= 1'b1; // see RULE4 see RULE8
        end
        if (state == LS_FINE && !err_zero && !fine_frozen && fine_at_lim) begin
          tune_out_of_bounds_flag <= 1'b1; // see RULE9
        end
      end
    end
  end

  // tuning values: software owns them in open loop, the loop otherwise
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      coarse_tune_value <= COARSE_RST;
      fine_tune_value <= FINE_RST;
    end else if (clk_en) begin
      if (!closed_req && wr_done && hit_val) begin
        coarse_tune_value <= pwdata[VAL_COARSE_LSB +: COARSE_W];
        fine_tune_value <= pwdata[VAL_FINE_LSB +: FINE_W];
      end else if (meas_valid && state == LS_COARSE && !coarse_done) begin
        coarse_tune_value <= coarse_next; // see RULE1
      end else if (meas_valid && state == LS_FINE && fine_step) begin
        fine_tune_value <= fine_next; // see RULE3 see RULE8
      end
    end
  end
endmodule

// file: testbench/flm_props.sv
// Purpose: port checks for flm_top
// Assumes: one pclk domain, apb answers one cycle after setup
// Notes: attached to every flm_top by bind
`timescale 1ns/1ps
module flm_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [flm_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic loop_reference_clock,
  input wire logic loop_osc_clock_out,
  input wire logic [flm_pkg::COARSE_W-1:0] coarse_tune_value,
  input wire logic [flm_pkg::FINE_W-1:0] fine_tune_value,
  input wire logic loop_osc_ready_flag,
  input wire logic irq
);
  import flm_pkg::*;
  logic ref_q;
  logic ref_up;
  logic acc;
  logic acc_w;
  // previous reference sample for edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_q <= 1'b0;
    end else begin
      ref_q <= loop_reference_clock;
    end
  end
  // reference edge and completed apb access
  assign ref_up = loop_reference_clock & ~ref_q;
  assign acc = psel & penable & pready;
  assign acc_w = acc & pwrite;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  apb_answer_a: assert property (psel && !penable && clk_en |=> pready)
    else $error("setup not answered");
  pready_once_a: assert property (pready |=> !pready) else $error("pready held");
  slverr_map_a: assert property (pready |-> pslverr == (paddr > OFF_INTMASK || paddr[1:0] != 2'h0))
    else $error("slverr wrong");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0) else $error("write data");
  coarse_step_a: assert property ($changed(coarse_tune_value) && !$past(acc_w) |->
    (coarse_tune_value - $past(coarse_tune_value)) inside {6'h01, 6'h3f}) else $error("coarse jump");
  fine_step_a: assert property ($changed(fine_tune_value) && !$past(acc_w) |->
    (fine_tune_value - $past(fine_tune_value)) inside {10'h001, 10'h3ff}) else $error("fine jump");
  fine_cause_a: assert property ($changed(fine_tune_value) |-> $past(acc_w) ||
    $past(ref_up, 1) || $past(ref_up, 2) || $past(ref_up, 3) || $past(ref_up, 4))
    else $error("fine moved without cause");
  irq_fall_a: assert property ($fell(irq) |->
    $past(acc, 1) || $past(acc, 2) || $past(acc, 3)) else $error("irq dropped alone");
  ready_fall_a: assert property ($fell(loop_osc_ready_flag) |->
    $past(acc_w && paddr == OFF_CTRL, 1) || $past(acc_w && paddr == OFF_CTRL, 2))
    else $error("ready dropped alone");
  cover property ($rose(loop_osc_ready_flag));
  cover property ($rose(irq));
  cover property (fine_tune_value == FINE_MAX);
endmodule
bind flm_top flm_props flm_props_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .loop_reference_clock(loop_reference_clock), .loop_osc_clock_out(loop_osc_clock_out),
  .coarse_tune_value(coarse_tune_value), .fine_tune_value(fine_tune_value),
  .loop_osc_ready_flag(loop_osc_ready_flag), .irq(irq));

// file: testbench/flm_top_tb_top.sv
// Purpose: register level test of flm_top
// Assumes: osc and reference made from a pclk cycle count
// Notes: 16 osc edges per reference period
`timescale 1ns/1ps
module flm_top_tb_top;
  import flm_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, ready, irq, ref_clk, osc;
  logic ref_run = 1'b0;
  logic clk_en = 1'b1;
  logic [COARSE_W-1:0] coarse;
  logic [FINE_W-1:0] fine;
  logic [7:0] cyc = 8'h00;
  int failures = 0;
  int comparisons = 0;
  always #12.5 pclk = ~pclk;
  // osc period 4 pclk, reference period 64 pclk
  always @(posedge pclk) cyc <= cyc + 8'h01;
  assign osc = cyc[1];
  assign ref_clk = cyc[5] & ref_run;
  flm_top flm_top_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .loop_reference_clock(ref_clk),
    .loop_osc_clock_out(osc), .coarse_tune_value(coarse), .fine_tune_value(fine),
    .loop_osc_ready_flag(ready), .irq(irq));
  task print_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, result left in rd and err
  task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      failures++;
      print_verdict;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait: 0 ready, 1 irq, 2 fine at top
  task wait_on(input int which, input int lim);
    int n;
    n = 0;
    while (!((which == 0 && ready === 1'b1) || (which == 1 && irq === 1'b1) ||
             (which == 2 && fine === FINE_MAX)) && n < lim) begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim) begin
      failures++;
      print_verdict;
    end
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, unmapped place, read-only status
    bus(0, OFF_CTRL, 0);
    chk(rd, 32'h0);
    bus(0, OFF_MUL, 0);
    chk(rd, {16'h0000, MUL_RST});
    bus(0, OFF_VAL, 0);
    chk(rd & 32'h0000ffff, {16'h0000, COARSE_RST, FINE_RST});
    bus(0, 8'h18, 0);
    chk({rd[30:0], err}, 32'h1);
    bus(1, OFF_STATUS, 32'h1f);
    bus(0, OFF_STATUS, 0);
    chk(rd, 32'h0);
    // open loop setup, then closed loop with exact ratio
    bus(1, OFF_INTMASK, 32'h6);
    bus(1, OFF_MUL, 32'h10);
    bus(1, OFF_VAL, 32'h7ff0);
    @(posedge pclk);
    chk({coarse, fine}, {COARSE_RST, 10'h3f0});
    ref_run <= 1'b1;
    bus(1, OFF_CTRL, 32'h3);
    wait_on(0, 200);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    wait_on(1, 300);
    repeat (140) @(posedge pclk);
    bus(0, OFF_STATUS, 0);
    chk(rd, 32'h7);
    bus(0, OFF_INTFLAG, 0);
    chk(rd, 32'h7);
    repeat (3) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
    bus(1, OFF_VAL, 0);
    bus(0, OFF_VAL, 0);
    chk(rd, {16'h0000, COARSE_RST, 10'h3f0});
    // hold set: a ratio error must not move fine
    bus(1, OFF_CTRL, 32'h7);
    bus(1, OFF_MUL, 32'h1a);
    repeat (300) @(posedge pclk);
    bus(0, OFF_VAL, 0);
    chk(rd, {16'hfff6, COARSE_RST, 10'h3f0});
    // hold clear: drift tracking up to the limit
    bus(1, OFF_CTRL, 32'h3);
    repeat (200) @(posedge pclk);
    chk({31'h0, fine > 10'h3f0}, 32'h1);
    bus(0, OFF_STATUS, 0);
    chk(rd & 32'h6, 32'h6);
    wait_on(2, 2000);
    repeat (200) @(posedge pclk);
    bus(0, OFF_STATUS, 0);
    chk(rd & 32'h8, 32'h8);
    // locks clear in open loop, then coarse search to its limit
    bus(1, OFF_CTRL, 32'h1);
    bus(0, OFF_STATUS, 0);
    chk(rd & 32'he, 32'h0);
    bus(1, OFF_MUL, 32'h38);
    bus(1, OFF_CTRL, 32'h3);
    repeat (260) @(posedge pclk);
    chk({31'h0, coarse > COARSE_RST}, 32'h1);
    repeat (2400) @(posedge pclk);
    chk({26'h0, coarse}, {26'h0, COARSE_MAX});
    bus(0, OFF_STATUS, 0);
    chk(rd & 32'h6, 32'h2);
    bus(1, OFF_CTRL, 32'h0);
    repeat (3) @(posedge pclk);
    chk({31'h0, ready}, 32'h0);
    // clock enable low freezes the ready count, release lets it finish
    bus(1, OFF_CTRL, 32'h1);
    clk_en <= 1'b0;
    repeat (256) @(posedge pclk);
    chk({31'h0, ready}, 32'h0);
    clk_en <= 1'b1;
    wait_on(0, 200);
    chk({31'h0, ready}, 32'h1);
    print_verdict;
  end
endmodule
